// file: src/psl_pkg.sv
/*
  constants and helpers for the supply status and level register group:
  register offsets, status bit positions, field widths and reset values.
  assumes a byte-addressed avalon-mm slave with 32-bit data.
*/
package psl_pkg;

  // register byte offsets
  localparam logic [7:0] PSL_OFS_STATUS = 8'h30;
  localparam logic [7:0] PSL_OFS_CORE = 8'h34;
  localparam logic [7:0] PSL_OFS_PLL = 8'h40;
  localparam logic [7:0] PSL_OFS_IRQ_STAT = 8'h50;
  localparam logic [7:0] PSL_OFS_IRQ_MASK = 8'h54;

  // number of status indications and their bit positions in the status word
  localparam int PSL_NSTS = 7;
  localparam int PSL_BIT_OSC = 24;
  localparam int PSL_BIT_PLL_GOOD = 19;
  localparam int PSL_BIT_CORE_GOOD = 16;
  localparam int PSL_BIT_ANA_ILIM = 9;
  localparam int PSL_BIT_CORE_ILIM = 8;
  localparam int PSL_BIT_ANA_SS = 1;
  localparam int PSL_BIT_CORE_SS = 0;

  // index of each indication in the internal status vector
  localparam int PSL_IX_CORE_SS = 0;
  localparam int PSL_IX_ANA_SS = 1;
  localparam int PSL_IX_CORE_ILIM = 2;
  localparam int PSL_IX_ANA_ILIM = 3;
  localparam int PSL_IX_CORE_GOOD = 4;
  localparam int PSL_IX_PLL_GOOD = 5;
  localparam int PSL_IX_OSC = 6;

  // level field widths and values held until the straps are caught
  localparam int PSL_CORE_W = 7;
  localparam int PSL_PLL_W = 3;
  localparam logic [6:0] PSL_CORE_RST = 7'h00;
  localparam logic [2:0] PSL_PLL_RST = 3'h0;

  // cycles after reset release before the synchronised straps are loaded
  localparam logic [2:0] PSL_STRAP_WAIT = 3'h4;

  // spreads the internal status vector onto the status word layout
  function automatic logic [31:0] psl_place(input logic [6:0] v);
    logic [31:0] w;
    w = 32'h0000_0000;
    w[PSL_BIT_CORE_SS] = v[PSL_IX_CORE_SS];
    w[PSL_BIT_ANA_SS] = v[PSL_IX_ANA_SS];
    w[PSL_BIT_CORE_ILIM] = v[PSL_IX_CORE_ILIM];
    w[PSL_BIT_ANA_ILIM] = v[PSL_IX_ANA_ILIM];
    w[PSL_BIT_CORE_GOOD] = v[PSL_IX_CORE_GOOD];
    w[PSL_BIT_PLL_GOOD] = v[PSL_IX_PLL_GOOD];
    w[PSL_BIT_OSC] = v[PSL_IX_OSC];
    return w;
  endfunction

  // gathers a status-layout word back into the internal vector
  function automatic logic [6:0] psl_gather(input logic [31:0] w);
    logic [6:0] v;
    v = 7'h00;
    v[PSL_IX_CORE_SS] = w[PSL_BIT_CORE_SS];
    v[PSL_IX_ANA_SS] = w[PSL_BIT_ANA_SS];
    v[PSL_IX_CORE_ILIM] = w[PSL_BIT_CORE_ILIM];
    v[PSL_IX_ANA_ILIM] = w[PSL_BIT_ANA_ILIM];
    v[PSL_IX_CORE_GOOD] = w[PSL_BIT_CORE_GOOD];
    v[PSL_IX_PLL_GOOD] = w[PSL_BIT_PLL_GOOD];
    v[PSL_IX_OSC] = w[PSL_BIT_OSC];
    return v;
  endfunction

endpackage

// file: src/psl_sync.sv
/*
  three-stage synchroniser for a group of pin levels.
  assumes the levels change slowly compared with clk_i; a change is passed
  on only once the second and third stages agree.
*/
`timescale 1ns/1ps
`default_nettype none
module psl_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // levels
  input wire logic [W-1:0] pin_i,
  output logic [W-1:0] lvl_o
);

  logic [W-1:0] st1; // first stage, read only by st2
  logic [W-1:0] st2; // second stage
  logic [W-1:0] st3; // third stage

  // shift chain; the filtered output moves only where st2 and st3 agree
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      st1 <= '0;
      st2 <= '0;
      st3 <= '0;
      lvl_o <= '0;
    end else begin
      st1 <= pin_i;
      st2 <= st1;
      st3 <= st2;
      lvl_o <= (st2 & st3) | (lvl_o & (st2 ^ st3));
    end
  end

endmodule
`default_nettype wire

// file: src/psl_irq.sv
/*
  sticky event flags with mask and one level interrupt.
  assumes events and the clear are single-cycle pulses on clk_i.
*/
`timescale 1ns/1ps
`default_nettype none
module psl_irq #(
  parameter int W = 7
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // events and software control
  input wire logic [W-1:0] event_i,
  input wire logic clear_i,
  input wire logic [W-1:0] mask_i,
  // state and interrupt
  output logic [W-1:0] sticky_o,
  output logic irq_o
);

  // a set in the clearing cycle wins, so no event is lost
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sticky_o <= '0;
    end else if (clear_i) begin
      sticky_o <= event_i;
    end else begin
      sticky_o <= sticky_o | event_i;
    end
  end

  // registered interrupt level, one cycle behind the flags
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(sticky_o & mask_i);
    end
  end

  irq_level_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    irq_o == $past(|(sticky_o & mask_i)))
    else $error("interrupt level does not follow masked flags");

endmodule
`default_nettype wire

// file: src/psl_regs.sv
/*
  supply status and level register group behind an avalon-mm slave.
  assumes: status and strap pins are asynchronous levels; strap pins are
  stable around reset release; the master follows avalon waitrequest rules.
*/
// Functional notes
// - status bit 24 shows oscillator stable
// - bit 19 pll rail good, bit 16 core good
// - bits 9/8 show buck converter current limiting
// - bits 1/0 show buck converter soft-start
// - core level field bits 6:0, 10 mV steps
// - core level resets from strap pins
// - pll level field bits 2:0, strap reset
`timescale 1ns/1ps
`default_nettype none
module psl_regs
  import psl_pkg::*;
(
  // clock and reset
  input wire logic clk_i,
  input wire logic arst_n_i,
  // avalon-mm slave
  input wire logic [7:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  // supply status pins
  input wire logic osc_stable_i,
  input wire logic pll_supply_rail_good_i,
  input wire logic core_supply_rail_good_i,
  input wire logic analog_buck_converter_ilim_i,
  input wire logic core_buck_converter_ilim_i,
  input wire logic analog_buck_converter_ss_i,
  input wire logic core_buck_converter_ss_i,
  // strap pins
  input wire logic [6:0] core_level_strap_i,
  input wire logic [2:0] pll_level_strap_i,
  // level outputs to the regulators
  output logic [6:0] core_level_o,
  output logic [2:0] pll_level_o,
  // interrupt
  output logic irq_o
);

  typedef enum logic [1:0] {
    PSL_ST_STRAP,
    PSL_ST_IDLE,
    PSL_ST_ACK
  } psl_state_t;

  psl_state_t state; // bus slave state
  psl_state_t next_state; // its next value
  logic [6:0] sts_raw; // status pins gathered
  logic [6:0] sts_q; // synchronised status
  logic [6:0] sts_prev; // status one cycle ago
  logic [6:0] sts_evt; // any change of a status line
  logic [9:0] strap_raw; // strap pins gathered
  logic [9:0] strap_s; // synchronised straps
  logic [2:0] strap_cnt; // cycles since reset release
  logic strap_load; // straps are caught this cycle
  logic req; // read or write requested
  logic take; // request is taken this cycle
  logic rd_take; // read taken this cycle
  logic wr_do; // write takes effect this cycle
  logic [31:0] next_rdata; // read data mux
  logic [6:0] irq_mask; // interrupt mask
  logic [6:0] irq_sticky; // sticky event flags
  logic irq_clear; // read of the event register

  // gather pins into the internal status order
  always_comb begin
    sts_raw = 7'h00;
    sts_raw[PSL_IX_OSC] = osc_stable_i;
    sts_raw[PSL_IX_PLL_GOOD] = pll_supply_rail_good_i;
    sts_raw[PSL_IX_CORE_GOOD] = core_supply_rail_good_i;
    sts_raw[PSL_IX_ANA_ILIM] = analog_buck_converter_ilim_i;
    sts_raw[PSL_IX_CORE_ILIM] = core_buck_converter_ilim_i;
    sts_raw[PSL_IX_ANA_SS] = analog_buck_converter_ss_i;
    sts_raw[PSL_IX_CORE_SS] = core_buck_converter_ss_i;
  end

  assign strap_raw = {core_level_strap_i, pll_level_strap_i};

  // status pins come from the analog side, so they are synchronised
  psl_sync #(
    .W(7)
  ) u_sts_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(sts_raw),
    .lvl_o(sts_q)
  );

  // straps too; they cannot be caught by the asynchronous reset itself
  psl_sync #(
    .W(10)
  ) u_strap_sync (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .pin_i(strap_raw),
    .lvl_o(strap_s)
  );

  // wait until the strap values have passed the synchroniser
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strap_cnt <= 3'h0;
    end else if (strap_cnt != PSL_STRAP_WAIT) begin
      strap_cnt <= strap_cnt + 3'h1;
    end
  end

  assign strap_load = (state == PSL_ST_STRAP) && (strap_cnt == PSL_STRAP_WAIT);

  // change detection feeding the event flags
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sts_prev <= 7'h00;
    end else begin
      sts_prev <= sts_q;
    end
  end

  assign sts_evt = sts_q ^ sts_prev;

  // bus handshake decode
  assign req = avs_read_i | avs_write_i;
  assign take = req && (state == PSL_ST_IDLE);
  assign rd_take = take && avs_read_i;
  assign wr_do = avs_write_i && (state == PSL_ST_ACK);
  assign irq_clear = rd_take && (avs_address_i == PSL_OFS_IRQ_STAT);

  // slave state: held busy until straps land, so no write is overwritten
  always_comb begin
    next_state = state;
    case (state)
      PSL_ST_STRAP: begin
        if (strap_load) begin
          next_state = PSL_ST_IDLE;
        end
      end
      PSL_ST_IDLE: begin
        if (req) begin
          next_state = PSL_ST_ACK;
        end
      end
      PSL_ST_ACK: begin
        next_state = PSL_ST_IDLE;
      end
      default: begin
        next_state = PSL_ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      state <= PSL_ST_STRAP;
    end else begin
      state <= next_state;
    end
  end

  // waitrequest drops for exactly the cycle in which the answer stands
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_waitrequest_o <= 1'b1;
    end else begin
      avs_waitrequest_o <= (next_state != PSL_ST_ACK);
    end
  end

  // read data mux; unmapped offsets and reserved bits read zero
  always_comb begin
    next_rdata = 32'h0000_0000;
    case (avs_address_i)
      PSL_OFS_STATUS: begin
        next_rdata = psl_place(sts_q);
      end
      PSL_OFS_CORE: begin
        next_rdata = {25'h0, core_level_o};
      end
      PSL_OFS_PLL: begin
        next_rdata = {29'h0, pll_level_o};
      end
      PSL_OFS_IRQ_STAT: begin
        next_rdata = psl_place(irq_sticky);
      end
      PSL_OFS_IRQ_MASK: begin
        next_rdata = psl_place(irq_mask);
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  // read data captured when the request is taken, stands one cycle on
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      avs_readdata_o <= 32'h0000_0000;
    end else if (rd_take) begin
      avs_readdata_o <= next_rdata;
    end
  end

  // core level: strap value at start-up, then software writes
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      core_level_o <= PSL_CORE_RST;
    end else if (strap_load) begin
      core_level_o <= strap_s[9:3];
    end else if (wr_do && avs_address_i == PSL_OFS_CORE && avs_byteenable_i[0]) begin
      // no slew limit here: stepping slowly is left to software
      core_level_o <= avs_writedata_i[6:0];
    end
  end

  // pll level: codes above 6 are stored as written, the regulator decides
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pll_level_o <= PSL_PLL_RST;
    end else if (strap_load) begin
      pll_level_o <= strap_s[2:0];
    end else if (wr_do && avs_address_i == PSL_OFS_PLL && avs_byteenable_i[0]) begin
      pll_level_o <= avs_writedata_i[2:0];
    end
  end

  // interrupt mask, same layout as the status word
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      irq_mask <= 7'h00;
    end else if (wr_do && avs_address_i == PSL_OFS_IRQ_MASK) begin
      irq_mask <= psl_gather(avs_writedata_i & {{8{avs_byteenable_i[3]}},
        {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
        {8{avs_byteenable_i[0]}}}) | (irq_mask & ~psl_gather({{8{avs_byteenable_i[3]}},
        {8{avs_byteenable_i[2]}}, {8{avs_byteenable_i[1]}},
        {8{avs_byteenable_i[0]}}}));
    end
  end

  // event flags; reading the event register clears them
  psl_irq #(
    .W(7)
  ) u_irq (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .event_i(sts_evt),
    .clear_i(irq_clear),
    .mask_i(irq_mask),
    .sticky_o(irq_sticky),
    .irq_o(irq_o)
  );

  // status bits on a read of the status word
  osc_bit_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && avs_address_i == PSL_OFS_STATUS)
    |=> avs_readdata_o[24] == $past(sts_q[PSL_IX_OSC]))
    else $error("oscillator bit wrong in status word");

  rail_good_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && avs_address_i == PSL_OFS_STATUS)
    |=> avs_readdata_o[19] == $past(sts_q[PSL_IX_PLL_GOOD])
    && avs_readdata_o[16] == $past(sts_q[PSL_IX_CORE_GOOD]))
    else $error("supply good bits wrong in status word");

  ilim_bits_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && avs_address_i == PSL_OFS_STATUS)
    |=> avs_readdata_o[9:8] == $past({sts_q[PSL_IX_ANA_ILIM], sts_q[PSL_IX_CORE_ILIM]}))
    else $error("current limit bits wrong in status word");

  soft_start_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && avs_address_i == PSL_OFS_STATUS)
    |=> avs_readdata_o[1:0] == $past({sts_q[PSL_IX_ANA_SS], sts_q[PSL_IX_CORE_SS]})
    && avs_readdata_o[7:2] == 6'h00)
    else $error("soft-start bits wrong in status word");

  core_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_do && avs_address_i == PSL_OFS_CORE && avs_byteenable_i[0])
    |=> core_level_o == $past(avs_writedata_i[6:0]))
    else $error("core level write not stored");

  core_strap_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    strap_load |=> core_level_o == $past(strap_s[9:3]) && !avs_waitrequest_o == 1'b0)
    else $error("core level not loaded from straps");

  pll_level_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (strap_load || (wr_do && avs_address_i == PSL_OFS_PLL && avs_byteenable_i[0]))
    |=> pll_level_o == $past(strap_load ? strap_s[2:0] : avs_writedata_i[2:0]))
    else $error("pll level not loaded");

  ro_write_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_do && (avs_address_i == PSL_OFS_STATUS || avs_address_i == PSL_OFS_IRQ_STAT))
    |=> $stable(core_level_o) && $stable(pll_level_o) && $stable(irq_mask))
    else $error("write to read-only register changed state");

  rsvd_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && (avs_address_i == PSL_OFS_CORE || avs_address_i == PSL_OFS_PLL))
    |=> avs_readdata_o[31:7] == 25'h0 && (avs_readdata_o[6:3] == 4'h0
    || $past(avs_address_i) == PSL_OFS_CORE))
    else $error("reserved level bits not zero");

  bus_answer_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (req && state == PSL_ST_IDLE) |=> !avs_waitrequest_o ##1 avs_waitrequest_o)
    else $error("bus answer not one cycle after request");

  // reading the event register empties it, apart from changes landing alongside
  evt_clear_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    irq_clear |=> irq_sticky == $past(sts_evt))
    else $error("event flags not cleared by read");

  // a change always leaves its flag set, even in a clearing cycle
  evt_set_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (sts_evt != 7'h00) |=> (irq_sticky & $past(sts_evt)) == $past(sts_evt))
    else $error("status change did not set its event flag");

  // no answer before the straps land, so an early write cannot be lost
  strap_busy_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (state == PSL_ST_STRAP) |-> avs_waitrequest_o)
    else $error("bus answered before straps were loaded");

  // the core field sits in byte 0, so a write without it changes nothing
  core_be_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (wr_do && avs_address_i == PSL_OFS_CORE && !avs_byteenable_i[0]) |=> $stable(core_level_o))
    else $error("core level changed without byte 0 enabled");

  // the mask keeps only the seven status positions, the rest reads zero
  mask_rsvd_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && avs_address_i == PSL_OFS_IRQ_MASK)
    |=> (avs_readdata_o & ~32'h0109_0303) == 32'h0000_0000)
    else $error("mask register shows reserved bits");

  // unmapped offsets answer with zero so software never sees stale data
  unmapped_zero_a: assert property (@(posedge clk_i) disable iff (!arst_n_i)
    (rd_take && avs_address_i != PSL_OFS_STATUS && avs_address_i != PSL_OFS_CORE
    && avs_address_i != PSL_OFS_PLL && avs_address_i != PSL_OFS_IRQ_STAT
    && avs_address_i != PSL_OFS_IRQ_MASK) |=> avs_readdata_o == 32'h0000_0000)
    else $error("unmapped offset read not zero");

endmodule
`default_nettype wire

// file: verification/psl_regs_tb_top.sv
/*
  self-checking bench for the supply status and level register group:
  a table of status patterns and register accesses, then level output,
  interrupt and mid-run reset cases.
  assumes the design answers avalon-mm requests with waitrequest and
  loads the level fields from the strap pins after reset release.
*/
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin check_count++; if ((got) !== (ex)) begin num_errors++; \
  $display("unexpected %s expected %h seen %h", nm, ex, got); end end
module psl_regs_tb_top;
  import psl_pkg::*;

  // one table row: pin pattern, optional write, then a read and its value
  typedef struct packed {
    logic [6:0] pins;
    logic wr;
    logic [7:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
    logic [31:0] exp;
  } psl_tb_row_t;

  // clock, reset and bus
  logic clk_i;
  logic arst_n_i;
  logic [7:0] avs_address_i;
  logic avs_read_i;
  logic avs_write_i;
  logic [31:0] avs_writedata_i;
  logic [3:0] avs_byteenable_i;
  logic [31:0] avs_readdata_o;
  logic avs_waitrequest_o;
  // status pins as one vector, in the package's index order
  logic [6:0] pins;
  logic [6:0] core_level_strap_i;
  logic [2:0] pll_level_strap_i;
  logic [6:0] core_level_o;
  logic [2:0] pll_level_o;
  logic irq_o;
  // bookkeeping
  int num_errors;
  int check_count;
  logic [31:0] rd;

  psl_regs psl_regs_inst (
    .clk_i(clk_i),
    .arst_n_i(arst_n_i),
    .avs_address_i(avs_address_i),
    .avs_read_i(avs_read_i),
    .avs_write_i(avs_write_i),
    .avs_writedata_i(avs_writedata_i),
    .avs_byteenable_i(avs_byteenable_i),
    .avs_readdata_o(avs_readdata_o),
    .avs_waitrequest_o(avs_waitrequest_o),
    .osc_stable_i(pins[PSL_IX_OSC]),
    .pll_supply_rail_good_i(pins[PSL_IX_PLL_GOOD]),
    .core_supply_rail_good_i(pins[PSL_IX_CORE_GOOD]),
    .analog_buck_converter_ilim_i(pins[PSL_IX_ANA_ILIM]),
    .core_buck_converter_ilim_i(pins[PSL_IX_CORE_ILIM]),
    .analog_buck_converter_ss_i(pins[PSL_IX_ANA_SS]),
    .core_buck_converter_ss_i(pins[PSL_IX_CORE_SS]),
    .core_level_strap_i(core_level_strap_i),
    .pll_level_strap_i(pll_level_strap_i),
    .core_level_o(core_level_o),
    .pll_level_o(pll_level_o),
    .irq_o(irq_o)
  );

  // ordinary cases; status words worked out by hand from the bit map
  psl_tb_row_t rows [16] = '{
    '{7'h00, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0000_0000},
    '{7'h40, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0100_0000},
    '{7'h20, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0008_0000},
    '{7'h10, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0001_0000},
    '{7'h08, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0000_0200},
    '{7'h04, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0000_0100},
    '{7'h02, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0000_0002},
    '{7'h01, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0000_0001},
    '{7'h7F, 1'b0, 8'h30, 32'h0, 4'h0, 32'h0109_0303},
    '{7'h00, 1'b1, 8'h30, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
    '{7'h00, 1'b1, 8'h34, 32'hFFFF_FFC5, 4'hF, 32'h0000_0045},
    '{7'h00, 1'b1, 8'h34, 32'h0000_0011, 4'hE, 32'h0000_0045},
    '{7'h00, 1'b1, 8'h40, 32'hFFFF_FFFC, 4'hF, 32'h0000_0004},
    '{7'h00, 1'b1, 8'h40, 32'h0000_0005, 4'hF, 32'h0000_0005},
    '{7'h00, 1'b1, 8'h60, 32'hFFFF_FFFF, 4'hF, 32'h0000_0000},
    '{7'h00, 1'b1, 8'h54, 32'hFFFF_FFFF, 4'hF, 32'h0109_0303}
  };

  // 25 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #20 clk_i = ~clk_i;
  end

  // one avalon access; request held until waitrequest is sampled low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d,
                     input logic [3:0] be, output logic [31:0] q);
    avs_address_i <= a;
    avs_writedata_i <= d;
    avs_byteenable_i <= be;
    avs_write_i <= wr;
    avs_read_i <= ~wr;
    @(posedge clk_i);
    // a stuck slave is left to the watchdog, which counts it as a mismatch
    while (avs_waitrequest_o !== 1'b0) begin
      @(posedge clk_i);
    end
    q = avs_readdata_o;
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
    // one idle edge so a following call never re-drives in the same step
    @(posedge clk_i);
  endtask

  // reset with given straps; levels must come back from the straps
  task automatic do_reset(input logic [6:0] cs, input logic [2:0] ps);
    core_level_strap_i <= cs;
    pll_level_strap_i <= ps;
    arst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    `CHK("waitrequest in reset", 1'b1, avs_waitrequest_o)
    `CHK("core level in reset", 7'h00, core_level_o)
    arst_n_i <= 1'b1;
    repeat (8) @(posedge clk_i);
    `CHK("core level from strap", cs, core_level_o)
    `CHK("pll level from strap", ps, pll_level_o)
    bus(1'b0, 8'h34, 32'h0, 4'hF, rd);
    `CHK("core reg after reset", {25'h0, cs}, rd)
    bus(1'b0, 8'h40, 32'h0, 4'hF, rd);
    `CHK("pll reg after reset", {29'h0, ps}, rd)
  endtask

  // single place where the run ends
  task automatic end_sim();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // watchdog: the whole sequence needs well under a thousand cycles
  initial begin
    repeat (5000) @(posedge clk_i);
    num_errors++;
    end_sim();
  end

  // main sequence
  initial begin
    num_errors = 0;
    check_count = 0;
    arst_n_i = 1'b0;
    avs_address_i = 8'h00;
    avs_read_i = 1'b0;
    avs_write_i = 1'b0;
    avs_writedata_i = 32'h0;
    avs_byteenable_i = 4'h0;
    pins = 7'h00;
    core_level_strap_i = 7'h00;
    pll_level_strap_i = 3'h0;
    @(posedge clk_i);
    // straps one code below the first written levels, so software steps stay single
    do_reset(7'h44, 3'h3);
    // table: pins settle through the synchroniser before each read
    foreach (rows[i]) begin
      pins <= rows[i].pins;
      repeat (6) @(posedge clk_i);
      if (rows[i].wr) begin
        bus(1'b1, rows[i].addr, rows[i].wdata, rows[i].be, rd);
      end
      bus(1'b0, rows[i].addr, 32'h0, 4'hF, rd);
      `CHK("row readback", rows[i].exp, rd)
    end
    // level outputs follow the fields; the core moves one 10 mV step
    `CHK("pll level out", 3'h5, pll_level_o)
    bus(1'b1, 8'h34, 32'h0000_0046, 4'hF, rd);
    `CHK("core level out", 7'h46, core_level_o)
    // interrupt: clear, unmask only the oscillator flag, then raise it
    bus(1'b0, 8'h50, 32'h0, 4'hF, rd);
    bus(1'b1, 8'h54, 32'h0100_0000, 4'hF, rd);
    repeat (3) @(posedge clk_i);
    `CHK("irq after clear", 1'b0, irq_o)
    pins <= 7'h40;
    repeat (8) @(posedge clk_i);
    `CHK("irq on osc change", 1'b1, irq_o)
    bus(1'b0, 8'h50, 32'h0, 4'hF, rd);
    `CHK("event flags osc", 32'h0100_0000, rd)
    repeat (3) @(posedge clk_i);
    `CHK("irq after read clear", 1'b0, irq_o)
    // a masked event sets its flag but leaves the line low
    pins <= 7'h41;
    repeat (8) @(posedge clk_i);
    `CHK("irq masked event", 1'b0, irq_o)
    bus(1'b0, 8'h50, 32'h0, 4'hF, rd);
    `CHK("event flags masked", 32'h0000_0001, rd)
    // byte enables gate the mask: only bytes 1 and 2 change here
    bus(1'b1, 8'h54, 32'hFFFF_FFFF, 4'h6, rd);
    bus(1'b0, 8'h54, 32'h0, 4'hF, rd);
    `CHK("mask byte enables", 32'h0109_0300, rd)
    // reset in mid-run with the straps at core 7'h46 and pll 3'h6
    do_reset(7'h46, 3'h6);
    end_sim();
  end

endmodule
`undef CHK
`default_nettype wire
